//--- rtl/battery_measurement_sequencer.sv
`timescale 1ns/1ps
module battery_measurement_sequencer
	import meas_seq_pkg::*;
#(
	parameter int unsigned SLOW_CYCLES = SLOW_CYC,
	parameter int unsigned SEC_CYCLES = SEC_CYC,
	parameter int unsigned SLOT_CYCLES = SLOT_BASE_CYC,
	parameter int unsigned FAST_CYCLES = FAST_BASE_CYC
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Avalon-MM slave.
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Voltage converter.
	output logic [2:0] o_vadc_sel,
	output logic o_vadc_start,
	input wire logic i_vadc_done,
	input wire logic [15:0] i_vadc_data,
	output logic o_ts_pullup_en,
	output logic o_ref_is_regulator,
	// Current converter.
	input wire logic signed [23:0] i_fast_raw,
	input wire logic signed [15:0] i_slow_raw,
	output logic o_cc_low_power,
	// Protection.
	output logic [4:0] o_cell_prot_en,
	output logic o_fet_disable,
	output logic o_shutdown_req
);
	// Selector codes 0..4 are cell pairs, 5..7 follow shared_type purposes.
	logic [31:0] ctrl_q;
	logic [15:0] ot_thr_q;
	logic [15:0] cell_q [NUM_CELLS];
	logic [15:0] top_q, reg18_q, gnd_q, die_q, ts_q;
	logic [23:0] fast_q;
	logic [15:0] slow_q;
	logic [47:0] charge_q;
	logic [31:0] time_q;
	logic [31:0] slot_cnt_q;
	logic [2:0] slot_q;
	logic busy_q;
	logic [2:0] shared_q;
	logic [2:0] boot_q;
	logic ack_q;
	logic ot_q;
	logic [2:0] cells;
	logic [4:0] used;
	wire logic ts_thermistor = ~ctrl_q[CTRL_TS_MODE];
	wire logic lp = ctrl_q[CTRL_CC_LP];
	wire logic sleep = ctrl_q[CTRL_SLEEP];
	wire sched_type sched = (boot_q != 3'h0) ? SCH_BOOT : (sleep ? SCH_SLEEP : SCH_NORMAL);
	assign cells = (ctrl_q[2:0] < 3'd2) ? 3'd2 : ((ctrl_q[2:0] > 3'd5) ? 3'd5 : ctrl_q[2:0]);
	// Bit k is pair VC(k+1)-VCk; shorted pairs depend on cell count.
	always_comb begin
		unique case (cells)
			3'd2: used = 5'b10001;
			3'd3: used = 5'b10011;
			3'd4: used = 5'b11011;
			default: used = 5'b11111;
		endcase
	end
	// Slot duration: boot runs the shortest slot, sleep stretches it.
	wire logic [4:0] slot_mult = {1'b0, ctrl_q[CTRL_SLOT_LSB +: 4]} + 5'd1;
	wire logic [31:0] slot_len = (sched == SCH_BOOT) ? SLOT_CYCLES :
		((sched == SCH_SLEEP) ? SLOT_CYCLES * SLEEP_MULT * slot_mult : SLOT_CYCLES * slot_mult);
	wire logic slot_is_shared = (slot_q == 3'd5);
	// Next real cell index after the current slot, or the shared slot.
	logic [2:0] next_slot;
	always_comb begin
		next_slot = 3'd5;
		for (int k = NUM_CELLS - 1; k >= 0; k--) begin
			if (used[k] && (slot_q == 3'd7 || 3'(k) > slot_q) && slot_q != 3'd5) begin
				next_slot = 3'(k);
			end
		end
	end
	wire logic slot_done = busy_q && i_vadc_done && (slot_cnt_q >= slot_len);
	// Sequencer: slot 7 means idle before the first cell slot of a loop.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			slot_q <= 3'd7;
			busy_q <= 1'b0;
			slot_cnt_q <= 32'h0;
			shared_q <= 3'h0;
			boot_q <= 3'(BOOT_LOOPS);
			o_vadc_start <= 1'b0;
			o_vadc_sel <= 3'h0;
			o_ts_pullup_en <= 1'b0;
			o_ref_is_regulator <= 1'b0;
		end else begin
			o_vadc_start <= 1'b0;
			if (!busy_q) begin
				slot_q <= next_slot;
				busy_q <= 1'b1;
				slot_cnt_q <= 32'h0;
				o_vadc_start <= 1'b1;
				o_vadc_sel <= (next_slot == 3'd5) ? 3'd5 + ((shared_q < 3'd3) ? shared_q : 3'd0) : next_slot;
				o_ts_pullup_en <= (next_slot == 3'd5) && shared_q == SH_TSENSE && ts_thermistor;
				o_ref_is_regulator <= (next_slot == 3'd5) && shared_q == SH_TSENSE && ts_thermistor;
			end else begin
				slot_cnt_q <= slot_cnt_q + 32'h1;
				if (slot_done) begin
					busy_q <= 1'b0;
					o_ts_pullup_en <= 1'b0;
					if (slot_is_shared) begin
						slot_q <= 3'd7;
						shared_q <= (shared_q == SH_TSENSE) ? 3'h0 : shared_q + 3'h1;
						if (boot_q != 3'h0) begin
							boot_q <= boot_q - 3'h1;
						end
					end
				end
			end
		end
	end
	// Result capture into the register of the converted purpose.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int k = 0; k < NUM_CELLS; k++) begin
				cell_q[k] <= 16'h0;
			end
			top_q <= 16'h0;
			reg18_q <= 16'h0;
			gnd_q <= 16'h0;
			die_q <= 16'h0;
			ts_q <= 16'h0;
		end else if (slot_done) begin
			if (!slot_is_shared) begin
				cell_q[slot_q] <= i_vadc_data;
			end else begin
				unique case (shared_q)
					SH_TOP: top_q <= i_vadc_data;
					SH_REG18: reg18_q <= i_vadc_data;
					SH_GND: gnd_q <= i_vadc_data;
					SH_DIE: die_q <= i_vadc_data;
					SH_TSENSE: ts_q <= i_vadc_data;
					default: ts_q <= ts_q;
				endcase
			end
		end
	end
	// Current filters: intervals scale by sixteen in low power.
	wire logic [31:0] fast_len = (FAST_CYCLES << ctrl_q[CTRL_FAST_LSB +: 2]) *
		(lp ? LP_MULT : 1);
	wire logic [31:0] slow_len = SLOW_CYCLES * (lp ? LP_MULT : 1);
	wire logic [31:0] sec_len = SEC_CYCLES;
	wire logic req = i_avs_read || i_avs_write;
	// The request is taken while waitrequest is high; the read word is ready by the next edge.
	wire logic take = req && !ack_q;
	// Writes land only at the edge that sees waitrequest low, so a stalled master changes nothing.
	wire logic wr_done = i_avs_write && ack_q;
	wire logic clear_cmd = wr_done && i_avs_address == ADDR_CMD &&
		i_avs_writedata == CMD_CLEAR;
	logic fast_tick;
	logic slow_tick;
	logic sec_tick;
	interval_tick i_fast_tick (
		.i_ref_clk,
		.i_reset_n,
		.i_hold(1'b0),
		.i_len(fast_len),
		.o_tick(fast_tick)
	);
	interval_tick i_slow_tick (
		.i_ref_clk,
		.i_reset_n,
		.i_hold(1'b0),
		.i_len(slow_len),
		.o_tick(slow_tick)
	);
	// The seconds divider restarts on a clear, so the timer counts whole seconds from zero.
	interval_tick i_sec_tick (
		.i_ref_clk,
		.i_reset_n,
		.i_hold(sleep || clear_cmd),
		.i_len(sec_len),
		.o_tick(sec_tick)
	);
	// One full-power sample is a quarter second of current: add it scaled by 2^30, sixteen times that in low power.
	wire logic [47:0] charge_step = {{2{i_slow_raw[15]}}, i_slow_raw, 30'h0} *
		(lp ? 48'd16 : 48'd1);
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fast_q <= 24'h0;
		end else if (fast_tick) begin
			fast_q <= i_fast_raw;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			slow_q <= 16'h0;
		end else if (slow_tick) begin
			slow_q <= i_slow_raw;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			charge_q <= 48'h0;
		end else if (clear_cmd) begin
			charge_q <= 48'h0;
		end else if (!sleep && slow_tick) begin
			charge_q <= charge_q + charge_step;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			time_q <= 32'h0;
		end else if (clear_cmd) begin
			time_q <= 32'h0;
		end else if (!sleep && sec_tick) begin
			time_q <= time_q + 32'h1;
		end
	end
	// Die overtemperature compares the signed die reading to the threshold.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ot_q <= 1'b0;
		end else begin
			ot_q <= $signed(die_q) > $signed(ot_thr_q);
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fet_disable <= 1'b0;
		end else begin
			o_fet_disable <= ot_q && ctrl_q[CTRL_OT_FET];
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_shutdown_req <= 1'b0;
		end else begin
			o_shutdown_req <= ot_q && ctrl_q[CTRL_OT_FET] && ctrl_q[CTRL_OT_SHUT];
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cell_prot_en <= 5'h0;
		end else begin
			o_cell_prot_en <= used;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cc_low_power <= 1'b0;
		end else begin
			o_cc_low_power <= lp;
		end
	end
	// Unused cell inputs read as zero; unmapped indices return the die reading.
	wire logic [31:0] word_status = {26'h0, ot_q, sched, slot_q};
	wire logic [31:0] word_cell01 = {used[1] ? cell_q[1] : 16'h0,
		used[0] ? cell_q[0] : 16'h0};
	wire logic [31:0] word_cell23 = {used[3] ? cell_q[3] : 16'h0,
		used[2] ? cell_q[2] : 16'h0};
	wire logic [31:0] word_fast = {{8{fast_q[23]}}, fast_q};
	wire logic [31:0] word_slow = {{16{slow_q[15]}}, slow_q};
	logic [31:0] rd;
	assign rd = (i_avs_address == ADDR_CTRL) ? ctrl_q :
		(i_avs_address == ADDR_STATUS) ? word_status :
		(i_avs_address == ADDR_CELL01) ? word_cell01 :
		(i_avs_address == ADDR_CELL23) ? word_cell23 :
		(i_avs_address == ADDR_CELL4) ? {16'h0, cell_q[4]} :
		(i_avs_address == ADDR_AUX0) ? {reg18_q, top_q} :
		(i_avs_address == ADDR_AUX1) ? {ts_q, gnd_q} :
		(i_avs_address == ADDR_FAST) ? word_fast :
		(i_avs_address == ADDR_SLOW) ? word_slow :
		(i_avs_address == ADDR_CHG_HI) ? {16'h0, charge_q[47:32]} :
		(i_avs_address == ADDR_CHG_LO) ? charge_q[31:0] :
		(i_avs_address == ADDR_TIME) ? time_q :
		(i_avs_address == ADDR_OT) ? {16'h0, ot_thr_q} :
		{16'h0, die_q};
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_q <= 1'b0;
			o_avs_readdata <= 32'h0;
		end else begin
			ack_q <= take;
			if (take) begin
				o_avs_readdata <= i_avs_read ? rd : 32'h0;
			end
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_done && i_avs_address == ADDR_CTRL) begin
			ctrl_q <= i_avs_writedata;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ot_thr_q <= OT_RESET;
		end else if (wr_done && i_avs_address == ADDR_OT) begin
			ot_thr_q <= i_avs_writedata[15:0];
		end
	end
	assign o_avs_waitrequest = take;
endmodule

module interval_tick (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Interval control.
	input wire logic i_hold,
	input wire logic [31:0] i_len,
	output logic o_tick
);
	logic [31:0] cnt_q;
	wire logic wrap = (cnt_q >= i_len - 32'h1);
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= (wrap || i_hold) ? 32'h0 : cnt_q + 32'h1;
		end
	end
	assign o_tick = wrap;
endmodule

//--- pkg/meas_seq_pkg.sv
// Notes on behaviour
// - Each loop converts every active cell, then one shared slot: 3 to 6 slots.
// - Slot width is programmable so a five-cell normal loop spans about 1.1 ms to 18 ms.
// - Sleep and normal schedules differ; a fast schedule runs after reset.
// - The converter also measures top-of-stack, the 1.8 V regulator and ground.
// - Only inputs designated as real cells are measured and reported.
// - Three cells use the top, second-lowest and lowest pairs; others are shorted.
// - Two cells use the top and lowest pairs; others are shorted.
// - Protections on unused cell inputs are disabled automatically.
// - Each real cell result is 16 bits at one millivolt per count.
// - A setting picks thermistor or general analog input for the sense pin.
// - Thermistor mode: pull-up on only while converting, regulator is reference.
// - Analog input mode: pull-up stays off, primary reference is used.
// - Temp-sense result is signed 16-bit counts; full scale is reference times 5/3.
// - The fast filter gives a 24-bit result at a programmable interval.
// - Full-power fast intervals are 366 us, 732 us, 1.46 ms or 2.93 ms.
// - Low-power current mode runs every interval sixteen times slower.
// - Slow filter outputs 16 bits every 250 ms, or every 4 s in low power.
// - Slow current accumulates into 48-bit charge with a 32-bit seconds timer.
// - A host command clears the accumulated charge and the timer.
// - Charge and time accumulation halt while in sleep mode.
// - Die temperature is measured within the loop and reported for the host.
// - Die temperature over threshold may disable the FETs and request shutdown.
package meas_seq_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned NUM_CELLS = 5;
	// Register word addresses (byte address / 4 not used: these are word indices).
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_CELL01 = 4'h2;
	localparam logic [3:0] ADDR_CELL23 = 4'h3;
	localparam logic [3:0] ADDR_CELL4 = 4'h4;
	localparam logic [3:0] ADDR_AUX0 = 4'h5;
	localparam logic [3:0] ADDR_AUX1 = 4'h6;
	localparam logic [3:0] ADDR_FAST = 4'h7;
	localparam logic [3:0] ADDR_SLOW = 4'h8;
	localparam logic [3:0] ADDR_CHG_HI = 4'h9;
	localparam logic [3:0] ADDR_CHG_LO = 4'ha;
	localparam logic [3:0] ADDR_TIME = 4'hb;
	localparam logic [3:0] ADDR_CMD = 4'hc;
	localparam logic [3:0] ADDR_OT = 4'hd;
	// Control register fields.
	localparam int unsigned CTRL_CELLS_LSB = 0;
	localparam int unsigned CTRL_SLOT_LSB = 4;
	localparam int unsigned CTRL_TS_MODE = 8;
	localparam int unsigned CTRL_FAST_LSB = 9;
	localparam int unsigned CTRL_CC_LP = 11;
	localparam int unsigned CTRL_SLEEP = 12;
	localparam int unsigned CTRL_OT_FET = 13;
	localparam int unsigned CTRL_OT_SHUT = 14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0005;
	localparam logic [31:0] CMD_CLEAR = 32'h0000_0001;
	localparam logic [15:0] OT_RESET = 16'h7fff;
	// Slot width: base 183 us, times 1..16; five-cell normal loop 1.1 ms to 17.6 ms.
	localparam int unsigned SLOT_BASE_NS = 183_000;
	localparam int unsigned SLOT_BASE_CYC = SLOT_BASE_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned SLEEP_MULT = 8;
	localparam int unsigned FAST_BASE_NS = 366_000;
	localparam int unsigned FAST_BASE_CYC = FAST_BASE_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned LP_MULT = 16;
	localparam int unsigned SLOW_MS = 250;
	localparam int unsigned SLOW_CYC = SLOW_MS * (CLK_HZ / 1000);
	localparam int unsigned SEC_CYC = CLK_HZ;
	localparam int unsigned BOOT_LOOPS = 4;
	typedef enum logic [2:0] {
		SH_TOP = 3'b000,
		SH_REG18 = 3'b001,
		SH_GND = 3'b010,
		SH_DIE = 3'b011,
		SH_TSENSE = 3'b100
	} shared_type;
	typedef enum logic [1:0] {
		SCH_BOOT = 2'b00,
		SCH_NORMAL = 2'b01,
		SCH_SLEEP = 2'b10
	} sched_type;
endpackage

//--- sim/meas_seq_monitor.sv
`timescale 1ns/1ps
module meas_seq_monitor
	import meas_seq_pkg::*;
#(
	parameter int unsigned SLOT_CYCLES = 20
) (
	// Watched ports.
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic o_avs_waitrequest,
	input wire logic [2:0] o_vadc_sel,
	input wire logic o_vadc_start,
	input wire logic o_ts_pullup_en,
	input wire logic o_ref_is_regulator,
	input wire logic o_cc_low_power,
	input wire logic [4:0] o_cell_prot_en,
	input wire logic o_fet_disable
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	logic [31:0] ctrl_q;
	logic [15:0] gap_q;
	logic [4:0] used;
	logic cfg_ok;
	assign cfg_ok = ctrl_q[2:0] >= 3'h2 && ctrl_q[2:0] <= 3'h5;
	assign used = ctrl_q[2:0] == 3'h2 ? 5'h11 : ctrl_q[2:0] == 3'h3 ? 5'h13 :
		ctrl_q[2:0] == 3'h4 ? 5'h1b : 5'h1f;
	// The mirror loads at the completing edge, so it never lags the block's own copy.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= CTRL_RESET;
			gap_q <= 16'hffff;
		end else begin
			if (i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_CTRL) begin
				ctrl_q <= i_avs_writedata;
			end
			gap_q <= o_vadc_start ? 16'h1 : gap_q + {15'h0, gap_q != 16'hffff};
		end
	end
	AST_WAIT_ONE: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("waitrequest held too long");
	AST_PULLUP_SLOT: assert property (
		$rose(o_ts_pullup_en) |-> o_ref_is_regulator && o_vadc_sel == 3'h5)
		else $error("pull-up outside sense slot");
	AST_PULLUP_OFF: assert property (
		ctrl_q[CTRL_TS_MODE] && $stable(ctrl_q) |-> !$rose(o_ts_pullup_en))
		else $error("pull-up in analog input mode");
	AST_PROT_MASK: assert property (
		$past(i_reset_n, 2) && cfg_ok && $stable(ctrl_q) && $past(ctrl_q, 2) == ctrl_q
		|-> o_cell_prot_en == used)
		else $error("protection mask wrong");
	AST_SEL_USED: assert property (
		o_vadc_start && o_vadc_sel < 3'h5 && cfg_ok && $stable(ctrl_q) |-> used[o_vadc_sel])
		else $error("unused cell converted");
	AST_SLOT_GAP: assert property (
		o_vadc_start |-> gap_q >= SLOT_CYCLES)
		else $error("slot shorter than width");
	AST_LP_FOLLOW: assert property (
		$past(i_reset_n, 2) && $stable(ctrl_q) |-> o_cc_low_power == ctrl_q[CTRL_CC_LP])
		else $error("low power flag wrong");
	AST_FET_GATE: assert property (
		!ctrl_q[CTRL_OT_FET] && $stable(ctrl_q) |-> !$rose(o_fet_disable))
		else $error("FETs disabled while not enabled");
	cover property (o_vadc_start && o_vadc_sel == 3'h6);
	cover property ($rose(o_ts_pullup_en));
	cover property ($rose(o_fet_disable));
endmodule
bind battery_measurement_sequencer meas_seq_monitor #(.SLOT_CYCLES(SLOT_CYCLES))
	i_meas_seq_monitor (.i_ref_clk, .i_reset_n, .i_avs_address, .i_avs_read, .i_avs_write,
	.i_avs_writedata, .o_avs_waitrequest, .o_vadc_sel, .o_vadc_start, .o_ts_pullup_en,
	.o_ref_is_regulator, .o_cc_low_power, .o_cell_prot_en, .o_fet_disable);

//--- sim/meas_cell_model.sv
`timescale 1ns/1ps
module meas_cell_model (
	// Clock, reset and pace.
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_slow,
	// Converter and filters.
	input wire logic [2:0] i_sel,
	input wire logic i_start,
	output logic o_done,
	output logic [15:0] o_data,
	output logic signed [23:0] o_fast_raw,
	output logic signed [15:0] o_slow_raw
);
	logic [5:0] cnt_q;
	logic [15:0] val_q;
	// Each input reads its select code above a base, so a misrouted slot shows.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 6'h0;
			val_q <= 16'h0;
		end else if (i_start) begin
			cnt_q <= 6'h1;
			val_q <= 16'h0e00 + {13'h0, i_sel};
		end else if (cnt_q != 6'h0 && cnt_q != 6'h28) begin
			cnt_q <= cnt_q + 6'h1;
		end
	end
	assign o_done = cnt_q >= (i_slow ? 6'h28 : 6'h2);
	assign o_data = o_done ? val_q : ~val_q;
	assign o_fast_raw = 24'sh012345;
	assign o_slow_raw = 16'sh0040;
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import meas_seq_pkg::*;
();
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [3:0] i_avs_address = 4'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic slow = 1'b0;
	logic [31:0] o_avs_readdata, q;
	logic o_avs_waitrequest, o_vadc_start, i_vadc_done, o_ts_pullup_en, o_ref_is_regulator;
	logic o_cc_low_power, o_fet_disable, o_shutdown_req;
	logic [2:0] o_vadc_sel;
	logic [15:0] i_vadc_data;
	logic signed [23:0] i_fast_raw;
	logic signed [15:0] i_slow_raw;
	logic [4:0] o_cell_prot_en;
	int err_total = 0;
	int cmp_count = 0;
	int pu_cnt = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) pu_cnt += int'(o_ts_pullup_en);
	battery_measurement_sequencer #(.SLOW_CYCLES(200), .SEC_CYCLES(100), .SLOT_CYCLES(20),
		.FAST_CYCLES(30)) i_battery_measurement_sequencer (.i_ref_clk, .i_reset_n,
		.i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
		.o_avs_waitrequest, .o_vadc_sel, .o_vadc_start, .i_vadc_done, .i_vadc_data,
		.o_ts_pullup_en, .o_ref_is_regulator, .i_fast_raw, .i_slow_raw, .o_cc_low_power,
		.o_cell_prot_en, .o_fet_disable, .o_shutdown_req);
	meas_cell_model i_meas_cell_model (.i_ref_clk, .i_reset_n, .i_slow(slow),
		.i_sel(o_vadc_sel), .i_start(o_vadc_start), .o_done(i_vadc_done),
		.o_data(i_vadc_data), .o_fast_raw(i_fast_raw), .o_slow_raw(i_slow_raw));
	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	// The request stands until the rising edge at which waitrequest is sampled low.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= a;
		i_avs_writedata <= d;
		@(posedge i_ref_clk);
		while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic t_regs();
		rchk("ctrl", ADDR_CTRL, CTRL_RESET);
		rchk("ot", ADDR_OT, {16'h0, OT_RESET});
		bus(1'b1, 4'hf, 32'hffff_ffff);
		rchk("ctrl kept", ADDR_CTRL, CTRL_RESET);
		cyc(1800);
		rchk("aux0", ADDR_AUX0, 32'h0e06_0e05);
		rchk("aux1", ADDR_AUX1, 32'h0e05_0e07);
		$display("test regs done");
	endtask
	task automatic t_cells();
		logic [4:0] m;
		for (int n = 2; n <= 5; n++) begin
			m = n == 2 ? 5'h11 : n == 3 ? 5'h13 : n == 4 ? 5'h1b : 5'h1f;
			bus(1'b1, ADDR_CTRL, 32'(n));
			cyc(600);
			chk("prot", {27'h0, o_cell_prot_en}, {27'h0, m});
			rchk("c01", ADDR_CELL01, {m[1] ? 16'h0e01 : 16'h0, 16'h0e00});
			rchk("c23", ADDR_CELL23, {m[3] ? 16'h0e03 : 16'h0, m[2] ? 16'h0e02 : 16'h0});
			rchk("c4", ADDR_CELL4, 32'h0e04);
		end
		$display("test cells done");
	endtask
	task automatic t_ts();
		bus(1'b1, ADDR_CTRL, 32'h105);
		cyc(40);
		pu_cnt = 0;
		cyc(900);
		chk("pullup analog", 32'(pu_cnt), 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h5);
		pu_cnt = 0;
		cyc(900);
		chk("pullup therm", {31'h0, pu_cnt > 0}, 32'h1);
		$display("test sense pin done");
	endtask
	task automatic t_charge();
		slow <= 1'b1;
		bus(1'b1, ADDR_CTRL, 32'h1005);
		bus(1'b1, ADDR_CMD, CMD_CLEAR);
		cyc(1000);
		rchk("sleep time", ADDR_TIME, 32'h0);
		rchk("sleep chg", ADDR_CHG_HI, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h5);
		bus(1'b1, ADDR_CMD, CMD_CLEAR);
		rchk("clr time", ADDR_TIME, 32'h0);
		cyc(450);
		bus(1'b0, ADDR_TIME, 32'h0);
		chk("time", {31'h0, q == 32'h4 || q == 32'h5}, 32'h1);
		bus(1'b0, ADDR_CHG_HI, 32'h0);
		chk("chg hi", {31'h0, q == 32'h20 || q == 32'h30}, 32'h1);
		rchk("chg lo", ADDR_CHG_LO, 32'h0);
		rchk("fast", ADDR_FAST, 32'h0001_2345);
		rchk("slow", ADDR_SLOW, 32'h0040);
		bus(1'b1, ADDR_CTRL, 32'h805);
		cyc(2);
		chk("low power", {31'h0, o_cc_low_power}, 32'h1);
		slow <= 1'b0;
		$display("test charge done");
	endtask
	task automatic t_ot();
		bus(1'b0, 4'he, 32'h0);
		bus(1'b1, ADDR_OT, {16'h0, q[15:0] - 16'h1});
		cyc(900);
		chk("fet kept", {31'h0, o_fet_disable}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h6005);
		cyc(900);
		chk("fet off", {31'h0, o_fet_disable}, 32'h1);
		chk("shutdown", {31'h0, o_shutdown_req}, 32'h1);
		$display("test overtemp done");
	endtask
	initial begin
		cyc(20);
		i_reset_n <= 1'b1;
		t_regs();
		t_cells();
		t_ts();
		t_charge();
		t_ot();
		close_out();
	end
	initial begin
		cyc(40000);
		err_total++;
		close_out();
	end
endmodule
